// *** rx_cfg_pkg.sv ***
// package: register map, field layouts, reset values for rx ring/pause config
package rx_cfg_pkg;
  // register byte addresses
  localparam logic [15:0] PAUSE_HIGH_MARK_ADDR = 16'h2168;
  localparam logic [15:0] SPLIT_SIZES_ADDR     = 16'h2170;
  localparam logic [15:0] RING_BASE_LOW_ADDR   = 16'h2800;
  localparam logic [15:0] RING_BASE_HIGH_ADDR  = 16'h2804;
  localparam logic [15:0] RING_LENGTH_ADDR     = 16'h2808;
  localparam logic [15:0] FLOW_CTRL_ADDR       = 16'h2100;
  localparam logic [15:0] PAUSE_STATUS_ADDR    = 16'h2104;

  // high water level field
  localparam int HWL_LSB = 3;
  localparam int HWL_MSB = 15;

  // split buffer size fields
  localparam int BUF0_LSB = 0;
  localparam int BUF0_MSB = 6;
  localparam int BUF1_LSB = 8;
  localparam int BUF1_MSB = 13;
  localparam int BUF2_LSB = 16;
  localparam int BUF2_MSB = 21;
  localparam int BUF3_LSB = 24;
  localparam int BUF3_MSB = 29;
  localparam logic [6:0] BUF0_RESET = 7'h02;
  localparam logic [5:0] BUF1_RESET = 6'h04;
  localparam logic [5:0] BUF2_RESET = 6'h04;
  localparam logic [5:0] BUF3_RESET = 6'h00;
  localparam int BUF0_UNIT_SHIFT = 7;
  localparam int BUFN_UNIT_SHIFT = 10;

  // ring base and length fields
  localparam int BASE_LOW_LSB = 4;
  localparam int LEN_LSB      = 7;
  localparam int LEN_MSB      = 19;
  localparam int DESC_SHIFT   = 4;

  // flow control register bits
  localparam int FC_RX_EN_BIT    = 0;
  localparam int FC_TX_EN_BIT    = 1;
  localparam int FC_MANUAL_BIT   = 2;
  localparam int FC_SPLIT_FMT_LSB = 4;
  localparam logic [1:0] FMT_LEGACY = 2'h0;
  localparam logic [1:0] FMT_SPLIT  = 2'h1;

  // legacy buffer size default when split format is off
  localparam logic [15:0] LEGACY_BUF_BYTES = 16'h0800;
endpackage : rx_cfg_pkg

// *** pause_trigger.sv ***
// module: edge-detects fifo level crossing the high mark into a pause pulse
`timescale 1ns/1ps
module pause_trigger
  import rx_cfg_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // level and threshold
  input  wire logic [15:0] fifo_level,
  input  wire logic [15:0] high_mark,
  input  wire logic        tx_enable,
  // request out
  output logic             pause_pulse,
  output logic             above_reg
);
  logic above_next;

  // at or above the mark; zero mark disables to avoid endless pauses
  assign above_next = (high_mark != 16'h0000) && (fifo_level >= high_mark);

  // track level so one pause per crossing, not one per cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      above_reg <= 1'b0;
    end else begin
      above_reg <= above_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_pulse <= 1'b0;
    end else begin
      pause_pulse <= above_next && !above_reg && tx_enable;
    end
  end

  // judged from the raw inputs, not from the shared compare above
  pulse_on_cross_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (high_mark != 16'h0000 && fifo_level >= high_mark && !above_reg
      && tx_enable) |=> pause_pulse)
    else $error("pause missed on threshold crossing");
  no_pause_off_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !$past(tx_enable) |-> !pause_pulse)
    else $error("pause sent while disabled");
endmodule : pause_trigger

// *** rx_ring_and_pause_config.sv ***
// module: apb register file for rx ring, split buffers and pause threshold
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module rx_ring_and_pause_config
  import rx_cfg_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // receive path status
  input  wire logic [15:0] fifo_level,
  input  wire logic        neg_rx_pause,
  input  wire logic        neg_tx_pause,
  // flow control outputs
  output logic             pause_request,
  output logic             rx_pause_active,
  // dma configuration outputs
  output logic      [63:0] ring_base,
  output logic      [19:0] ring_bytes,
  output logic      [15:0] ring_descriptors,
  output logic      [15:0] buf0_bytes,
  output logic      [15:0] buf1_bytes,
  output logic      [15:0] buf2_bytes,
  output logic      [15:0] buf3_bytes
);

  logic [12:0] high_water_level_reg;
  logic [6:0]  first_buffer_size_reg;
  logic [5:0]  second_buffer_size_reg;
  logic [5:0]  third_buffer_size_reg;
  logic [5:0]  fourth_buffer_size_reg;
  logic [27:0] rx_ring_base_low_reg;
  logic [31:0] rx_ring_base_high_reg;
  logic [12:0] ring_length_field_reg;
  logic        receive_pause_enable_reg;
  logic        transmit_pause_enable_reg;
  logic        manual_flow_reg;
  logic [1:0]  descriptor_format_select_reg;
  logic [15:0] pause_count_reg;
  logic        wr_en;
  logic        rd_en;
  logic        addr_hit;
  logic        tx_enable;
  logic        pause_pulse;
  logic        above_mark;
  logic [15:0] high_mark_bytes;
  logic [31:0] rdata_next;

  // single-cycle access: ready during every access phase
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;

  // decode used by the error flag only; the read mux decodes paddr itself
  always_comb begin
    case (paddr)
      PAUSE_HIGH_MARK_ADDR, SPLIT_SIZES_ADDR, RING_BASE_LOW_ADDR,
      RING_BASE_HIGH_ADDR, RING_LENGTH_ADDR, FLOW_CTRL_ADDR,
      PAUSE_STATUS_ADDR: addr_hit = 1'b1;
      default:           addr_hit = 1'b0;
    endcase
  end

  // unmapped addresses answer with an error, reads as zero
  assign pslverr = psel && penable && !addr_hit;

  // pause threshold: only bits 15:3 are stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_water_level_reg <= 13'h0000;
    end else if (wr_en && paddr == PAUSE_HIGH_MARK_ADDR) begin
      high_water_level_reg <= pwdata[HWL_MSB:HWL_LSB];
    end
  end

  // split sizes; zero in a lower buffer is not forced upward in hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_buffer_size_reg  <= BUF0_RESET;
      second_buffer_size_reg <= BUF1_RESET;
      third_buffer_size_reg  <= BUF2_RESET;
      fourth_buffer_size_reg <= BUF3_RESET;
    end else if (wr_en && paddr == SPLIT_SIZES_ADDR) begin
      first_buffer_size_reg  <= pwdata[BUF0_MSB:BUF0_LSB];
      second_buffer_size_reg <= pwdata[BUF1_MSB:BUF1_LSB];
      third_buffer_size_reg  <= pwdata[BUF2_MSB:BUF2_LSB];
      fourth_buffer_size_reg <= pwdata[BUF3_MSB:BUF3_LSB];
    end
  end

  // ring base: low nibble never stored, so alignment is guaranteed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ring_base_low_reg  <= 28'h0000000;
      rx_ring_base_high_reg <= 32'h00000000;
    end else if (wr_en) begin
      if (paddr == RING_BASE_LOW_ADDR) begin
        rx_ring_base_low_reg <= pwdata[31:BASE_LOW_LSB];
      end
      if (paddr == RING_BASE_HIGH_ADDR) begin
        rx_ring_base_high_reg <= pwdata;
      end
    end
  end

  // ring length in 128-byte units
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ring_length_field_reg <= 13'h0000;
    end else if (wr_en && paddr == RING_LENGTH_ADDR) begin
      ring_length_field_reg <= pwdata[LEN_MSB:LEN_LSB];
    end
  end

  // flow control configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_pause_enable_reg     <= 1'b0;
      transmit_pause_enable_reg    <= 1'b0;
      manual_flow_reg              <= 1'b0;
      descriptor_format_select_reg <= FMT_LEGACY;
    end else if (wr_en && paddr == FLOW_CTRL_ADDR) begin
      receive_pause_enable_reg     <= pwdata[FC_RX_EN_BIT];
      transmit_pause_enable_reg    <= pwdata[FC_TX_EN_BIT];
      manual_flow_reg              <= pwdata[FC_MANUAL_BIT];
      descriptor_format_select_reg <=
        pwdata[FC_SPLIT_FMT_LSB+1:FC_SPLIT_FMT_LSB];
    end
  end

  // manual configuration overrides the negotiated result
  assign tx_enable = manual_flow_reg ? transmit_pause_enable_reg
                                     : neg_tx_pause;
  assign rx_pause_active = manual_flow_reg ? receive_pause_enable_reg
                                           : neg_rx_pause;

  assign high_mark_bytes = {high_water_level_reg, 3'h0};

  // crossing detector lives apart so it can be reused for other marks
  pause_trigger i_pause_trigger (
    .pclk        (pclk),
    .presetn     (presetn),
    .fifo_level  (fifo_level),
    .high_mark   (high_mark_bytes),
    .tx_enable   (tx_enable),
    .pause_pulse (pause_pulse),
    .above_reg   (above_mark)
  );

  assign pause_request = pause_pulse;

  // count sent pauses; saturates rather than wrapping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_count_reg <= 16'h0000;
    end else if (pause_pulse && pause_count_reg != 16'hFFFF) begin
      pause_count_reg <= pause_count_reg + 16'h0001;
    end
  end

  // read mux; reserved bits always zero
  always_comb begin
    rdata_next = 32'h00000000;
    case (paddr)
      PAUSE_HIGH_MARK_ADDR: rdata_next = {16'h0000, high_mark_bytes};
      SPLIT_SIZES_ADDR: rdata_next = {2'h0, fourth_buffer_size_reg,
        2'h0, third_buffer_size_reg, 2'h0, second_buffer_size_reg,
        1'b0, first_buffer_size_reg};
      RING_BASE_LOW_ADDR: rdata_next = {rx_ring_base_low_reg, 4'h0};
      RING_BASE_HIGH_ADDR: rdata_next = rx_ring_base_high_reg;
      RING_LENGTH_ADDR: rdata_next = {12'h000, ring_length_field_reg,
        7'h00};
      FLOW_CTRL_ADDR: rdata_next = {26'h0000000,
        descriptor_format_select_reg, 1'b0, manual_flow_reg,
        transmit_pause_enable_reg, receive_pause_enable_reg};
      PAUSE_STATUS_ADDR: rdata_next = {15'h0000, above_mark,
        pause_count_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  // read data captured in setup, stable through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= rdata_next;
    end
  end

  // dma-facing view of the configuration, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ring_base        <= 64'h0000000000000000;
      ring_bytes       <= 20'h00000;
      ring_descriptors <= 16'h0000;
    end else begin
      ring_base  <= {rx_ring_base_high_reg, rx_ring_base_low_reg,
                     4'h0};
      ring_bytes <= {ring_length_field_reg, 7'h00};
      // 128 bytes per unit over 16-byte descriptors: eight each
      ring_descriptors <= {ring_length_field_reg, 3'h0};
    end
  end

  // buffer sizes in bytes; split sizes only in split format
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf0_bytes <= LEGACY_BUF_BYTES;
      buf1_bytes <= 16'h0000;
      buf2_bytes <= 16'h0000;
      buf3_bytes <= 16'h0000;
    end else if (descriptor_format_select_reg == FMT_SPLIT) begin
      buf0_bytes <= {2'h0, first_buffer_size_reg, 7'h00};
      buf1_bytes <= {second_buffer_size_reg, 10'h000};
      buf2_bytes <= {third_buffer_size_reg, 10'h000};
      buf3_bytes <= {fourth_buffer_size_reg, 10'h000};
    end else begin
      buf0_bytes <= LEGACY_BUF_BYTES;
      buf1_bytes <= 16'h0000;
      buf2_bytes <= 16'h0000;
      buf3_bytes <= 16'h0000;
    end
  end

  // register bus: reserved and ignored bits read as zero
  mark_low_zero_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (rd_en && paddr == PAUSE_HIGH_MARK_ADDR) |=> prdata[2:0] == 3'h0
      && prdata[31:16] == 16'h0000)
    else $error("high mark reserved bits not zero");
  split_rsvd_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (rd_en && paddr == SPLIT_SIZES_ADDR) |=> prdata[7] == 1'b0
      && prdata[15:14] == 2'h0 && prdata[23:22] == 2'h0
      && prdata[31:30] == 2'h0)
    else $error("split reserved bits not zero");
  base_low_zero_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (rd_en && paddr == RING_BASE_LOW_ADDR) |=> prdata[3:0] == 4'h0)
    else $error("base low nibble not zero");
  len_rsvd_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (rd_en && paddr == RING_LENGTH_ADDR) |=> prdata[6:0] == 7'h00
      && prdata[31:20] == 12'h000)
    else $error("ring length reserved bits not zero");
  // register bus: a write lands in its own field only
  mark_write_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wr_en && paddr == PAUSE_HIGH_MARK_ADDR) |=>
      high_mark_bytes[HWL_MSB:HWL_LSB] == $past(pwdata[HWL_MSB:HWL_LSB]))
    else $error("high mark not stored");
  buf0_write_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wr_en && paddr == SPLIT_SIZES_ADDR) |=>
      first_buffer_size_reg == $past(pwdata[BUF0_MSB:BUF0_LSB]))
    else $error("buffer 0 size not stored");
  bufn_write_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wr_en && paddr == SPLIT_SIZES_ADDR) |=>
      fourth_buffer_size_reg == $past(pwdata[BUF3_MSB:BUF3_LSB]))
    else $error("buffer 3 size not stored");
  base_low_write_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wr_en && paddr == RING_BASE_LOW_ADDR) |=>
      rx_ring_base_low_reg == $past(pwdata[31:BASE_LOW_LSB]))
    else $error("ring base low not stored");
  base_high_write_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wr_en && paddr == RING_BASE_HIGH_ADDR) |=>
      rx_ring_base_high_reg == $past(pwdata))
    else $error("ring base high not stored");
  len_write_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wr_en && paddr == RING_LENGTH_ADDR) |=>
      ring_length_field_reg == $past(pwdata[LEN_MSB:LEN_LSB]))
    else $error("ring length not stored");
  // flow control: manual enables win, pause request lasts one cycle
  manual_tx_sel_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (manual_flow_reg && !transmit_pause_enable_reg) |=> !pause_request)
    else $error("manual pause enable ignored");
  manual_rx_sel_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (manual_flow_reg && !receive_pause_enable_reg) |-> !rx_pause_active)
    else $error("manual receive pause enable ignored");
  pause_single_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    pause_request |=> !pause_request)
    else $error("pause request longer than one cycle");
  // dma view: registered copies one cycle behind the registers
  base_out_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    ##1 ring_base[63:32] == $past(rx_ring_base_high_reg))
    else $error("ring base high not propagated");
  desc_mult_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    ring_descriptors == ring_bytes[19:4] && ring_descriptors[2:0] == 3'h0)
    else $error("descriptor count not multiple of eight");
  legacy_size_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    $past(descriptor_format_select_reg) != FMT_SPLIT
      |-> buf0_bytes == LEGACY_BUF_BYTES)
    else $error("split sizes used in legacy format");

  // main scenarios worth seeing in a run
  pause_sent_c: cover property (@(posedge pclk) disable iff (!presetn)
    pause_request);
  split_used_c: cover property (@(posedge pclk) disable iff (!presetn)
    descriptor_format_select_reg == FMT_SPLIT ##1 buf1_bytes != 16'h0000);
  bad_addr_c: cover property (@(posedge pclk) disable iff (!presetn)
    pslverr);
  ring_set_c: cover property (@(posedge pclk) disable iff (!presetn)
    ring_descriptors != 16'h0000);
  tx_blocked_c: cover property (@(posedge pclk) disable iff (!presetn)
    above_mark && !tx_enable);
endmodule : rx_ring_and_pause_config

// *** rx_fifo_model.sv ***
// partner: receive fifo fill model and pause frame counter
`timescale 1ns/1ps
module rx_fifo_model #(
  parameter int FIFO_BYTES = 1024
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // fill target set by the bench
  input  wire logic [15:0] target,
  // block side
  output logic      [15:0] fifo_level,
  input  wire logic        pause_request,
  output int               pause_count
);
  // fill in 8-byte beats so the mark is hit exactly; drain at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_level <= 16'h0000;
    end else if (fifo_level < target && fifo_level < FIFO_BYTES) begin
      fifo_level <= fifo_level + 16'h0008;
    end else if (fifo_level > target) begin
      fifo_level <= target;
    end
  end

  // every sampled request is one xoff frame on the wire
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_count <= 0;
    end else if (pause_request === 1'b1) begin
      pause_count <= pause_count + 1;
    end
  end
endmodule : rx_fifo_model

// *** rx_ring_and_pause_config_test.sv ***
// testbench: register map, ring outputs and pause generation
`timescale 1ns/1ps
module rx_ring_and_pause_config_test;
  import rx_cfg_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [15:0] paddr, fifo_level, target;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, neg_rx_pause, neg_tx_pause;
  logic        pause_request, rx_pause_active;
  logic [63:0] ring_base;
  logic [19:0] ring_bytes;
  logic [15:0] ring_descriptors, buf0_bytes, buf1_bytes;
  logic [15:0] buf2_bytes, buf3_bytes;
  int          pause_count, err_count, total_checks;

  rx_ring_and_pause_config i_rx_ring_and_pause_config (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fifo_level(fifo_level),
    .neg_rx_pause(neg_rx_pause), .neg_tx_pause(neg_tx_pause),
    .pause_request(pause_request), .rx_pause_active(rx_pause_active),
    .ring_base(ring_base), .ring_bytes(ring_bytes),
    .ring_descriptors(ring_descriptors), .buf0_bytes(buf0_bytes),
    .buf1_bytes(buf1_bytes), .buf2_bytes(buf2_bytes),
    .buf3_bytes(buf3_bytes));

  rx_fifo_model i_rx_fifo_model (
    .pclk(pclk), .presetn(presetn), .target(target),
    .fifo_level(fifo_level), .pause_request(pause_request),
    .pause_count(pause_count));

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; entered just after a rising edge
  task automatic xfer(input logic [15:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd(input string what, input logic [15:0] a,
                    input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    xfer(a, 1'b0, 32'h0000_0000, r, e);
    chk(what, exp, r);
    chk("pslverr", 32'h0000_0000, {31'h0, e});
  endtask : rd

  task automatic t_reset;
    rd("mark", PAUSE_HIGH_MARK_ADDR, 32'h0000_0000);
    rd("sizes", SPLIT_SIZES_ADDR, 32'h0004_0402);
    rd("base lo", RING_BASE_LOW_ADDR, 32'h0000_0000);
    rd("base hi", RING_BASE_HIGH_ADDR, 32'h0000_0000);
    rd("len", RING_LENGTH_ADDR, 32'h0000_0000);
    chk("buf0 legacy", 32'h0000_0800, {16'h0, buf0_bytes});
    $display("test reset finished");
  endtask : t_reset

  task automatic t_split;
    wr(PAUSE_HIGH_MARK_ADDR, 32'hFFFF_FFFF);
    rd("mark mask", PAUSE_HIGH_MARK_ADDR, 32'h0000_FFF8);
    wr(SPLIT_SIZES_ADDR, 32'hFFFF_FFFF);
    rd("sizes mask", SPLIT_SIZES_ADDR, 32'h3F3F_3F7F);
    chk("buf1 legacy", 32'h0, {16'h0, buf1_bytes});
    wr(FLOW_CTRL_ADDR, 32'h0000_0010);
    @(posedge pclk); // byte sizes trail the registers by one cycle
    chk("buf0 max", 32'h0000_3F80, {16'h0, buf0_bytes});
    chk("buf3 max", 32'h0000_FC00, {16'h0, buf3_bytes});
    // mixed sizes: 256 bytes, 4 KB, 1 KB, zero
    wr(SPLIT_SIZES_ADDR, 32'h0001_0402);
    @(posedge pclk);
    chk("buf0", 32'h0000_0100, {16'h0, buf0_bytes});
    chk("buf1", 32'h0000_1000, {16'h0, buf1_bytes});
    chk("buf2", 32'h0000_0400, {16'h0, buf2_bytes});
    chk("buf3", 32'h0000_0000, {16'h0, buf3_bytes});
    wr(FLOW_CTRL_ADDR, 32'h0000_0000);
    @(posedge pclk);
    chk("buf0 back", 32'h0000_0800, {16'h0, buf0_bytes});
    $display("test split finished");
  endtask : t_split

  task automatic t_ring;
    // ring set up with no receive traffic running
    wr(RING_BASE_LOW_ADDR, 32'hFFFF_FFFF);
    wr(RING_BASE_HIGH_ADDR, 32'h1234_5678);
    wr(RING_LENGTH_ADDR, 32'hFFFF_FFFF);
    rd("base lo", RING_BASE_LOW_ADDR, 32'hFFFF_FFF0);
    rd("base hi", RING_BASE_HIGH_ADDR, 32'h1234_5678);
    rd("len", RING_LENGTH_ADDR, 32'h000F_FF80);
    chk("base hi out", 32'h1234_5678, ring_base[63:32]);
    chk("base lo out", 32'hFFFF_FFF0, ring_base[31:0]);
    chk("bytes", 32'h000F_FF80, {12'h0, ring_bytes});
    chk("descs", 32'h0000_FFF8, {16'h0, ring_descriptors});
    $display("test ring finished");
  endtask : t_ring

  task automatic t_unmapped;
    logic [31:0] r;
    logic        e;
    wr(16'h2174, 32'hFFFF_FFFF);
    xfer(16'h2174, 1'b0, 32'h0, r, e);
    chk("hole data", 32'h0, r);
    chk("hole err", 32'h1, {31'h0, e});
    rd("sizes kept", SPLIT_SIZES_ADDR, 32'h0001_0402);
    $display("test unmapped finished");
  endtask : t_unmapped

  // settle window is generous: 8 bytes a cycle plus one cycle pulse
  task automatic fill(input logic [15:0] lv, input int n);
    target <= lv;
    repeat (40) @(posedge pclk);
    chk("pauses", n, pause_count);
  endtask : fill

  task automatic t_pause;
    wr(PAUSE_HIGH_MARK_ADDR, 32'h0000_0040);
    wr(FLOW_CTRL_ADDR, 32'h0000_0006);
    fill(16'h0038, 0);
    fill(16'h0040, 1);
    fill(16'h0080, 1);
    rd("status hi", PAUSE_STATUS_ADDR, 32'h0001_0001);
    fill(16'h0000, 1);
    fill(16'h0040, 2);
    fill(16'h0000, 2);
    // manual mode, transmit off: negotiated value must not leak in
    wr(FLOW_CTRL_ADDR, 32'h0000_0004);
    neg_tx_pause <= 1'b1;
    neg_rx_pause <= 1'b1;
    fill(16'h0040, 2);
    fill(16'h0000, 2);
    chk("rx off", 32'h0, {31'h0, rx_pause_active});
    wr(FLOW_CTRL_ADDR, 32'h0000_0000);
    chk("rx neg", 32'h1, {31'h0, rx_pause_active});
    fill(16'h0040, 3);
    fill(16'h0000, 3);
    neg_rx_pause <= 1'b0;
    wr(FLOW_CTRL_ADDR, 32'h0000_0005);
    chk("rx man", 32'h1, {31'h0, rx_pause_active});
    rd("flow", FLOW_CTRL_ADDR, 32'h0000_0005);
    rd("status", PAUSE_STATUS_ADDR, 32'h0000_0003);
    $display("test pause finished");
  endtask : t_pause

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    err_count    = 0;
    total_checks = 0;
    presetn      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 16'h0000;
    pwdata       = 32'h0000_0000;
    target       = 16'h0000;
    neg_rx_pause = 1'b0;
    neg_tx_pause = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_split;
    t_ring;
    t_unmapped;
    t_pause;
    wrap_up;
  end

  // tests need well under 2000 cycles
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    wrap_up;
  end
endmodule : rx_ring_and_pause_config_test
